// *** hw/lip_ctrl.sv ***
// level interrupt prioritizer: system registers, request path and cpu handshake
//
// Functional notes
// R01: bit 0 of mode is global enable
// R02: reset clears mode bits 7, 1, 0
// R03: mode bits 4..2 pick fast level
// R04: mask bit n gates level n
// R05: levels grouped A(0,1) B(2-4) C(5-7)
// R06: priority bits 7,4,1 order groups
// R07: priority bit 5 orders group C
// R08: bits 2 and 3 order group B
// R09: priority bit 0 orders levels 0, 1
// R10: within level, lowest vector source wins
// R11: status bit n shows level n request
// R12: reset clears request status
// R13: disabled requests still recorded, not serviced
// R14: hardware pending set, request, ack clears
// R15: hardware type only on four sources
// R16: software pending stays until zero written
// R17: fixed source to level mapping
// R18: overflow has enable only, match both
// R19: software changes source bits after disable
// R20: accept clears enable, return sets it
// R21: service needs enable, mask, win, source
// R22: mode bit 1 enables fast handling
// R23: own table for other priority codes
`timescale 1ns/1ps
module lip_ctrl import lip_pkg::*; (
  // clock and reset
  input  wire logic                clk_sys,
  input  wire logic                sys_rst,
  // register port
  input  wire logic [7:0]          reg_addr,
  input  wire logic [7:0]          reg_wdata,
  input  wire logic                reg_wr,
  input  wire logic                reg_rd,
  output logic      [7:0]          reg_rdata,
  // cpu core
  input  wire logic                global_on_instruction,
  input  wire logic                global_off_instruction,
  input  wire logic                cpu_acknowledge,
  input  wire logic                interrupt_return,
  output logic                     int_request,
  output logic      [2:0]          int_level,
  output logic      [4:0]          int_source,
  output logic                     int_fast,
  output logic                     int_in_service,
  // peripheral sources
  input  wire logic [LIP_SRCS-1:0] src_event,
  input  wire logic [LIP_SRCS-1:0] src_enable,
  input  wire logic [LIP_SRCS-1:0] src_sw_clear,
  output logic      [LIP_SRCS-1:0] src_sw_pending
);

  logic [7:0]          level_mask_q;
  logic [7:0]          system_mode_q;
  logic [7:0]          level_priority_q;
  logic [7:0]          request_status;
  logic [7:0]          qual_req;
  logic [LIP_SRCS-1:0] src_pending;
  logic [LIP_SRCS-1:0] src_active;
  logic                win_valid;
  logic [2:0]          win_level;
  logic [4:0]          win_src;
  logic                accept;
  logic                req_d;
  logic                req_q;
  logic [2:0]          lvl_q;
  logic [4:0]          src_q;
  logic                fast_q;
  logic [7:0]          rdata_q;
  lip_state_t          state_q;
  lip_state_t          state_d;

  ////////////////////////////////////////////////////////////////////////////
  // address decode, shared by read and write paths
  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    return a == ofs;
  endfunction : hit

  // lowest source index of a level that is active
  function automatic logic [4:0] first_src(input logic [LIP_SRCS-1:0] act, input logic [2:0] lvl);
    logic [4:0] r;
    r = 5'h00;
    for (int i = LIP_SRCS - 1; i >= 0; i--) begin
      if (act[i] && lip_src_level(i) == lvl) begin
        r = 5'(i);
      end
    end
    return r;
  endfunction : first_src

  ////////////////////////////////////////////////////////////////////////////
  // source pending flags
  lip_src_pending #(
    .N (LIP_SRCS)
  ) u_pending (
    .clk_sys      (clk_sys),
    .sys_rst      (sys_rst),
    .src_event    (src_event),
    .src_sw_clear (src_sw_clear),
    .ack_pulse    (accept),
    .ack_src      (src_q),
    .src_pending  (src_pending)
  );

  // overflow and counter sources carry no visible pending bit
  assign src_sw_pending = src_pending & ~LIP_HW_CLEARED; // R18
  assign src_active     = src_pending & src_enable;      // R21

  // level status, recorded even while global enable is off
  always_comb begin
    request_status = LIP_RST_REQ_STATUS;                 // R12
    for (int i = 0; i < LIP_SRCS; i++) begin
      if (src_active[i]) begin
        request_status[lip_src_level(i)] = 1'b1;         // R11 R13 R17
      end
    end
  end

  assign qual_req = request_status & level_mask_q;       // R04

  ////////////////////////////////////////////////////////////////////////////
  // level arbitration
  lip_level_arbiter u_arbiter (
    .clk_sys        (clk_sys),
    .sys_rst        (sys_rst),
    .level_req      (qual_req),
    .level_priority (level_priority_q),
    .win_valid      (win_valid),
    .win_level      (win_level)
  );

  assign win_src = first_src(src_active, win_level);     // R10

  ////////////////////////////////////////////////////////////////////////////
  // request to the cpu
  assign accept = cpu_acknowledge && req_q;
  assign req_d  = system_mode_q[LIP_SYM_GE] && win_valid && !accept; // R21 R13

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      req_q  <= 1'b0;
      lvl_q  <= 3'h0;
      src_q  <= 5'h00;
      fast_q <= 1'b0;
    end else begin
      req_q  <= req_d;
      lvl_q  <= win_level;
      src_q  <= win_src;
      fast_q <= system_mode_q[LIP_SYM_FAST_EN] &&
                system_mode_q[LIP_SYM_FSEL_HI:LIP_SYM_FSEL_LO] == win_level; // R22 R03
    end
  end

  assign int_request    = req_q;
  assign int_level      = lvl_q;
  assign int_source     = src_q;
  assign int_fast       = fast_q;
  assign int_in_service = (state_q == LIP_SERVICE);

  ////////////////////////////////////////////////////////////////////////////
  // service state
  always_comb begin
    case (state_q)
      LIP_IDLE:    state_d = accept ? LIP_SERVICE : LIP_IDLE;
      LIP_SERVICE: state_d = interrupt_return ? LIP_IDLE : LIP_SERVICE;
      default:     state_d = LIP_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      state_q <= LIP_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // system mode register
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      system_mode_q <= LIP_RST_SYS_MODE;                 // R02 R03
    end else begin
      if (reg_wr && hit(reg_addr, LIP_OFS_SYS_MODE)) begin
        system_mode_q <= reg_wdata & LIP_SYM_WR_MASK;    // R01 R03
      end
      if (global_off_instruction) begin
        system_mode_q[LIP_SYM_GE] <= 1'b0;               // R01
      end
      if (global_on_instruction || interrupt_return) begin
        system_mode_q[LIP_SYM_GE] <= 1'b1;               // R01 R20
      end
      if (accept) begin
        system_mode_q[LIP_SYM_GE] <= 1'b0;               // R20
      end
    end
  end

  // mask and priority registers
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      level_mask_q <= LIP_RST_LEVEL_MASK;                // R04
    end else if (reg_wr && hit(reg_addr, LIP_OFS_LEVEL_MASK)) begin
      level_mask_q <= reg_wdata;
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      level_priority_q <= LIP_RST_LEVEL_PRIO;
    end else if (reg_wr && hit(reg_addr, LIP_OFS_LEVEL_PRIO)) begin
      level_priority_q <= reg_wdata;                     // R06 R23
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read path, status is read only
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      rdata_q <= LIP_RD_UNMAPPED;
    end else if (reg_rd) begin
      if (hit(reg_addr, LIP_OFS_REQ_STATUS)) begin
        rdata_q <= request_status;                       // R11
      end else if (hit(reg_addr, LIP_OFS_LEVEL_MASK)) begin
        rdata_q <= level_mask_q;
      end else if (hit(reg_addr, LIP_OFS_SYS_MODE)) begin
        rdata_q <= system_mode_q;
      end else if (hit(reg_addr, LIP_OFS_LEVEL_PRIO)) begin
        rdata_q <= level_priority_q;
      end else begin
        rdata_q <= LIP_RD_UNMAPPED;
      end
    end
  end

  assign reg_rdata = rdata_q;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  a_accept_clears_ge: assert property (accept |=> !system_mode_q[LIP_SYM_GE]) // R20
    else $error("accept left global enable set");
  a_return_sets_ge: assert property (interrupt_return && !accept && !global_off_instruction && !reg_wr // R20
                                     |=> system_mode_q[LIP_SYM_GE])
    else $error("return did not set global enable");
  a_off_clears_ge: assert property (global_off_instruction && !global_on_instruction && !interrupt_return // R01
                                    |=> !system_mode_q[LIP_SYM_GE])
    else $error("global off ignored");
  a_req_needs_ge: assert property (req_q |-> $past(system_mode_q[LIP_SYM_GE]) && $past(qual_req) != 8'h00) // R21
    else $error("request without enable or unmasked level");
  a_status_read: assert property (reg_rd && hit(reg_addr, LIP_OFS_REQ_STATUS) // R11
                                  |=> reg_rdata == $past(request_status))
    else $error("status read mismatch");
  a_mask_blocks: assert property (level_mask_q == 8'h00 ##1 level_mask_q == 8'h00 |-> !req_q) // R04
    else $error("request with all levels masked");
  a_service_hold: assert property (accept |=> int_in_service ##1 (int_in_service || $past(interrupt_return))) // R20
    else $error("service state lost");

  a_on_sets_ge: assert property (global_on_instruction && !accept // R01
                                 |=> system_mode_q[LIP_SYM_GE])
    else $error("global on ignored");
  a_mode_write: assert property (reg_wr && hit(reg_addr, LIP_OFS_SYS_MODE) && !accept // R01 R03
                                 && !global_on_instruction && !global_off_instruction && !interrupt_return
                                 |=> system_mode_q == ($past(reg_wdata) & LIP_SYM_WR_MASK))
    else $error("mode write lost");
  a_mode_unused: assert property ((system_mode_q & ~LIP_SYM_WR_MASK) == 8'h00) // R03
    else $error("unused mode bits set");
  a_mask_write: assert property (reg_wr && hit(reg_addr, LIP_OFS_LEVEL_MASK) // R04
                                 |=> level_mask_q == $past(reg_wdata))
    else $error("mask write lost");
  a_prio_write: assert property (reg_wr && hit(reg_addr, LIP_OFS_LEVEL_PRIO) // R06
                                 |=> level_priority_q == $past(reg_wdata))
    else $error("priority write lost");
  a_accept_drops_req: assert property (accept // R20
                                       |=> !req_q)
    else $error("request stayed up after accept");
  a_return_leaves_svc: assert property (interrupt_return && !accept // R20
                                        |=> !int_in_service)
    else $error("return did not leave service");
  a_req_winner: assert property (req_q // R21
                                 |-> $past(qual_req[win_level]))
    else $error("request level not unmasked");
  a_src_enabled: assert property (req_q // R10 R21
                                  |-> $past(src_active[win_src]))
    else $error("request source not active");
  a_src_level_map: assert property (req_q // R17
                                    |-> lip_src_level(int_source) == int_level)
    else $error("source and level disagree");
  a_fast_level: assert property (int_fast // R22 R03
                                 |-> $past(system_mode_q[LIP_SYM_FAST_EN])
                                     && int_level == $past(system_mode_q[LIP_SYM_FSEL_HI:LIP_SYM_FSEL_LO]))
    else $error("fast flag on wrong level");

  c_accept:  cover property (req_q ##1 accept);
  c_return:  cover property (accept ##[1:20] interrupt_return);
  c_fast:    cover property (req_q && fast_q);
  c_polling: cover property (!system_mode_q[LIP_SYM_GE] && request_status != 8'h00);

endmodule : lip_ctrl

// *** hw/lip_level_arbiter.sv ***
// group and subgroup priority arbitration among the eight levels
`timescale 1ns/1ps
module lip_level_arbiter import lip_pkg::*; (
  // clock and reset, for checks only
  input  wire logic       clk_sys,
  input  wire logic       sys_rst,
  // requests and priority setting
  input  wire logic [7:0] level_req,
  input  wire logic [7:0] level_priority,
  // winner
  output logic            win_valid,
  output logic      [2:0] win_level
);

  logic       va, vb, vc;
  logic [2:0] la, lb, lc;
  logic [2:0] grp_code;

  always_comb begin
    va = |level_req[1:0];                     // R05
    la = (level_priority[LIP_IPR_A] ? !level_req[1] : level_req[0]) ? 3'h0 : 3'h1; // R09
    vb = |level_req[4:2];
    lb = level_priority[LIP_IPR_B_SUB] ? (level_req[4] ? 3'h4 : 3'h3)
                                       : (level_req[3] ? 3'h3 : 3'h4); // R08
    if (level_req[2] && (!level_priority[LIP_IPR_B] || !(|level_req[4:3]))) begin
      lb = 3'h2;                              // R08
    end
    vc = |level_req[7:5];
    if (!level_priority[LIP_IPR_C]) begin
      lc = level_req[5] ? 3'h5 : (level_req[6] ? 3'h6 : 3'h7); // R07
    end else begin
      lc = level_req[7] ? 3'h7 : (level_req[6] ? 3'h6 : 3'h5); // R07
    end
    grp_code = {level_priority[LIP_IPR_GRP_H], level_priority[LIP_IPR_GRP_M], level_priority[LIP_IPR_GRP_L]};
    win_valid = va || vb || vc;
    case (lip_grp_ord_t'(grp_code))           // R06 R23
      LIP_ORD_BCA: win_level = vb ? lb : (vc ? lc : la);
      LIP_ORD_CBA: win_level = vc ? lc : (vb ? lb : la);
      LIP_ORD_BAC: win_level = vb ? lb : (va ? la : lc);
      LIP_ORD_CAB: win_level = vc ? lc : (va ? la : lb);
      LIP_ORD_ACB: win_level = va ? la : (vc ? lc : lb);
      default:     win_level = va ? la : (vb ? lb : lc);
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  a_order_bca: assert property (grp_code == 3'b001 && vb |-> win_level inside {3'h2, 3'h3, 3'h4}) // R06
    else $error("order 001 did not favour group B");
  a_order_cba: assert property (grp_code == 3'b101 && vc |-> win_level inside {3'h5, 3'h6, 3'h7}) // R06
    else $error("order 101 did not favour group C");
  a_group_a_sel: assert property (level_req[1:0] == 2'b11 && grp_code == 3'b000 // R09
                                  |-> win_level == (level_priority[LIP_IPR_A] ? 3'h1 : 3'h0))
    else $error("group A order wrong");

endmodule : lip_level_arbiter

// *** hw/lip_pkg.sv ***
// shared constants, types and decode functions of the level interrupt prioritizer
package lip_pkg;

  localparam int LIP_LEVELS = 8;
  localparam int LIP_SRCS   = 23;

  // register offsets
  localparam logic [7:0] LIP_OFS_REQ_STATUS = 8'hDC;
  localparam logic [7:0] LIP_OFS_LEVEL_MASK = 8'hDD;
  localparam logic [7:0] LIP_OFS_SYS_MODE   = 8'hDE;
  localparam logic [7:0] LIP_OFS_LEVEL_PRIO = 8'hFF;

  // reset values (undefined fields come up as zero)
  localparam logic [7:0] LIP_RST_REQ_STATUS = 8'h00;
  localparam logic [7:0] LIP_RST_LEVEL_MASK = 8'h00;
  localparam logic [7:0] LIP_RST_SYS_MODE   = 8'h00;
  localparam logic [7:0] LIP_RST_LEVEL_PRIO = 8'h00;
  localparam logic [7:0] LIP_RD_UNMAPPED    = 8'h00;

  // system mode fields
  localparam int LIP_SYM_GE      = 0;
  localparam int LIP_SYM_FAST_EN = 1;
  localparam int LIP_SYM_FSEL_LO = 2;
  localparam int LIP_SYM_FSEL_HI = 4;
  localparam int LIP_SYM_EXT     = 7;
  localparam logic [7:0] LIP_SYM_WR_MASK = 8'h9F;

  // level priority fields
  localparam int LIP_IPR_A     = 0;
  localparam int LIP_IPR_GRP_L = 1;
  localparam int LIP_IPR_B     = 2;
  localparam int LIP_IPR_B_SUB = 3;
  localparam int LIP_IPR_GRP_M = 4;
  localparam int LIP_IPR_C     = 5;
  localparam int LIP_IPR_GRP_H = 7;

  // source indices, ascending index is ascending vector address
  localparam int LIP_SRC_T0_OVF   = 0;
  localparam int LIP_SRC_T0_MATCH = 1;
  localparam int LIP_SRC_T1_OVF   = 2;
  localparam int LIP_SRC_T1_MATCH = 3;
  localparam int LIP_SRC_CA       = 4;
  localparam int LIP_SRC_T2_OVF   = 5;
  localparam int LIP_SRC_T2_MATCH = 6;
  localparam int LIP_SRC_P2_LO    = 7;
  localparam int LIP_SRC_P2_HI    = 11;
  localparam int LIP_SRC_P0_LO    = 15;
  localparam int LIP_SRC_P0_HI    = 19;

  // sources whose pending flag is cleared by acknowledge
  localparam logic [LIP_SRCS-1:0] LIP_HW_CLEARED = 23'h000035;

  typedef enum logic [2:0] {
    LIP_ORD_ABC = 3'b000,
    LIP_ORD_BCA = 3'b001,
    LIP_ORD_ABC2 = 3'b010,
    LIP_ORD_BAC = 3'b011,
    LIP_ORD_CAB = 3'b100,
    LIP_ORD_CBA = 3'b101,
    LIP_ORD_ACB = 3'b110,
    LIP_ORD_ABC3 = 3'b111
  } lip_grp_ord_t;

  typedef enum logic [0:0] {
    LIP_IDLE    = 1'b0,
    LIP_SERVICE = 1'b1
  } lip_state_t;

  function automatic logic [2:0] lip_src_level(input int unsigned i);
    if (i <= LIP_SRC_T0_MATCH) return 3'h0;
    else if (i <= LIP_SRC_T1_MATCH) return 3'h1;
    else if (i == LIP_SRC_CA) return 3'h2;
    else if (i <= LIP_SRC_T2_MATCH) return 3'h3;
    else if (i < LIP_SRC_P2_HI) return 3'h4;
    else if (i < LIP_SRC_P0_LO) return 3'h5;
    else if (i < LIP_SRC_P0_HI) return 3'h6;
    else return 3'h7;
  endfunction : lip_src_level

endpackage : lip_pkg

// *** hw/lip_src_pending.sv ***
// per-source pending flags of both clearing types
`timescale 1ns/1ps
module lip_src_pending import lip_pkg::*; #(
  parameter int N = LIP_SRCS
) (
  // clock and reset
  input  wire logic         clk_sys,
  input  wire logic         sys_rst,
  // source side
  input  wire logic [N-1:0] src_event,
  input  wire logic [N-1:0] src_sw_clear,
  // acknowledge side
  input  wire logic         ack_pulse,
  input  wire logic [4:0]   ack_src,
  // flags
  output logic      [N-1:0] src_pending
);

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  for (genvar i = 0; i < N; i++) begin : g_src
    logic clr;
    assign clr = LIP_HW_CLEARED[i] ? (ack_pulse && ack_src == 5'(i)) : src_sw_clear[i]; // R15
    always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
        src_pending[i] <= 1'b0;
      end else if (src_event[i]) begin
        src_pending[i] <= 1'b1;   // R14
      end else if (clr) begin
        src_pending[i] <= 1'b0;   // R14 R16
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  a_event_sets: assert property (src_event[0] |=> src_pending[0]) // R14
    else $error("event did not set pending");
  a_sw_hold: assert property (src_pending[1] && !src_sw_clear[1] |=> src_pending[1]) // R16
    else $error("sw pending cleared without write");
  a_hw_ack_clear: assert property (ack_pulse && ack_src == 5'h00 && !src_event[0] |=> !src_pending[0]) // R15
    else $error("hw pending not cleared by ack");

endmodule : lip_src_pending

// *** verif/lip_cpu_model.sv ***
// cpu core model: acknowledges requests and returns from service
`timescale 1ns/1ps
module lip_cpu_model (
  // clock and reset
  input  wire logic       clk_sys,
  input  wire logic       sys_rst,
  // test control
  input  wire logic       cpu_auto,
  input  wire logic [3:0] ack_wait,
  // controller side
  input  wire logic       int_request,
  input  wire logic [4:0] int_source,
  output logic            cpu_acknowledge,
  output logic            interrupt_return,
  // observation
  output logic      [4:0] last_src,
  output logic      [7:0] done_cnt
);
  logic [1:0] phase_q;
  logic [4:0] wait_q;
  //////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      phase_q          <= 2'h0;
      wait_q           <= 5'h00;
      cpu_acknowledge  <= 1'b0;
      interrupt_return <= 1'b0;
      last_src         <= 5'h00;
      done_cnt         <= 8'h00;
    end else begin
      cpu_acknowledge  <= 1'b0;
      interrupt_return <= 1'b0;
      case (phase_q)
        2'h0: begin
          if (cpu_auto && int_request) begin
            if (wait_q == {1'b0, ack_wait}) begin
              cpu_acknowledge <= 1'b1;
              last_src        <= int_source;
              wait_q          <= 5'h00;
              phase_q         <= 2'h1;
            end else begin
              wait_q <= wait_q + 5'h01;
            end
          end else begin
            wait_q <= 5'h00;
          end
        end
        2'h1: begin
          if (wait_q == 5'h14) begin
            interrupt_return <= 1'b1;
            done_cnt         <= done_cnt + 8'h01;
            phase_q          <= 2'h2;
          end else begin
            wait_q <= wait_q + 5'h01;
          end
        end
        default: phase_q <= 2'h0;
      endcase
    end
  end
endmodule : lip_cpu_model

// *** verif/lip_ctrl_tb_top.sv ***
// testbench of the level interrupt prioritizer
`timescale 1ns/1ps
module lip_ctrl_tb_top import lip_pkg::*; ();
  logic                clk_sys, sys_rst, reg_wr, reg_rd, ge_on, ge_off, cpu_auto;
  logic [7:0]          reg_addr, reg_wdata, reg_rdata, done_cnt;
  logic [3:0]          ack_wait;
  logic                cpu_ack, int_ret, int_request, int_fast, int_in_service;
  logic [2:0]          int_level;
  logic [4:0]          int_source, last_src;
  logic [LIP_SRCS-1:0] src_event, src_enable, src_sw_clear, src_sw_pending;
  int                  error_cnt, checks, cyc, n;
  logic [7:0]          prio_t [13] = '{8'h00, 8'h01, 8'h02, 8'h06, 8'h0E, 8'h82, 8'hA2, 8'hA2, 8'h80, 8'h12,
                                       8'h90, 8'h10, 8'h92};
  logic [7:0]          mask_t [13] = '{8'hFF, 8'h03, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h7F, 8'h1F, 8'h1F,
                                       8'hFC, 8'hFC, 8'hFC};
  logic [2:0]          lvl_t  [13] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h7, 3'h6, 3'h0, 3'h2, 3'h5, 3'h2, 3'h2};
  logic [4:0]          first_src [8] = '{5'h00, 5'h02, 5'h04, 5'h05, 5'h07, 5'h0B, 5'h0F, 5'h13};
  logic [4:0]          svc_t [4] = '{5'h00, 5'h02, 5'h04, 5'h05};
  //////////////////////////////////////////////////////////////////////////////
  lip_ctrl dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .global_on_instruction(ge_on),
    .global_off_instruction(ge_off), .cpu_acknowledge(cpu_ack), .interrupt_return(int_ret),
    .int_request(int_request), .int_level(int_level), .int_source(int_source), .int_fast(int_fast),
    .int_in_service(int_in_service), .src_event(src_event), .src_enable(src_enable),
    .src_sw_clear(src_sw_clear), .src_sw_pending(src_sw_pending));
  lip_cpu_model cpu (.clk_sys(clk_sys), .sys_rst(sys_rst), .cpu_auto(cpu_auto), .ack_wait(ack_wait),
    .int_request(int_request), .int_source(int_source), .cpu_acknowledge(cpu_ack),
    .interrupt_return(int_ret), .last_src(last_src), .done_cnt(done_cnt));
  //////////////////////////////////////////////////////////////////////////////
  function automatic logic [2:0] lvl_of(input int i);
    if (i < 2) return 3'h0;
    if (i < 4) return 3'h1;
    if (i == 4) return 3'h2;
    if (i < 7) return 3'h3;
    if (i < 11) return 3'h4;
    if (i < 15) return 3'h5;
    if (i < 19) return 3'h6;
    return 3'h7;
  endfunction : lvl_of
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      error_cnt++;
    end
  endtask : check
  task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk_sys);
    reg_wr    <= 1'b0;
  endtask : reg_write
  task automatic reg_read(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk_sys);
    reg_rd   <= 1'b0;
    #1;
    check(reg_rdata, e);
  endtask : reg_read
  task automatic src_pulse(input logic [LIP_SRCS-1:0] ev, input logic [LIP_SRCS-1:0] clr);
    @(posedge clk_sys);
    src_event    <= ev;
    src_sw_clear <= clr;
    @(posedge clk_sys);
    src_event    <= '0;
    src_sw_clear <= '0;
  endtask : src_pulse
  task automatic instr(input logic on, input logic off);
    @(posedge clk_sys);
    ge_on  <= on;
    ge_off <= off;
    @(posedge clk_sys);
    ge_on  <= 1'b0;
    ge_off <= 1'b0;
  endtask : instr
  task automatic settle();
    repeat (3) @(posedge clk_sys);
    #1;
  endtask : settle
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : complete_run
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  initial begin
    cyc = 0;
    forever begin
      @(posedge clk_sys);
      cyc++;
      if (cyc > 20000) begin
        error_cnt++;
        complete_run();
      end
    end
  end
  initial begin
    error_cnt = 0; checks = 0;
    sys_rst = 1'b1; reg_wr = 1'b0; reg_rd = 1'b0; reg_addr = 8'h00; reg_wdata = 8'h00;
    ge_on = 1'b0; ge_off = 1'b0; cpu_auto = 1'b0; ack_wait = 4'h0;
    src_event = '0; src_enable = '0; src_sw_clear = '0;
    repeat (6) @(posedge clk_sys);
    sys_rst <= 1'b0;
    // reset values, read-only status, unmapped place
    reg_read(LIP_OFS_SYS_MODE, 8'h00);
    reg_read(LIP_OFS_REQ_STATUS, 8'h00);
    reg_write(LIP_OFS_REQ_STATUS, 8'hFF);
    reg_read(LIP_OFS_REQ_STATUS, 8'h00);
    reg_read(8'h10, LIP_RD_UNMAPPED);
    reg_write(LIP_OFS_SYS_MODE, 8'hFF);
    reg_read(LIP_OFS_SYS_MODE, 8'h9F);
    reg_write(LIP_OFS_SYS_MODE, 8'h00);
    instr(1'b1, 1'b0);
    reg_read(LIP_OFS_SYS_MODE, 8'h01);
    instr(1'b0, 1'b1);
    reg_read(LIP_OFS_SYS_MODE, 8'h00);
    reg_write(LIP_OFS_LEVEL_MASK, 8'hFF);
    reg_read(LIP_OFS_LEVEL_MASK, 8'hFF);
    $display("test registers done");
    // mapping and pending types with global enable off
    for (int i = 0; i < LIP_SRCS; i++) begin
      src_enable <= LIP_SRCS'(1) << i;
      src_pulse(LIP_SRCS'(1) << i, '0);
      reg_read(LIP_OFS_REQ_STATUS, 8'h01 << lvl_of(i));
      check(int_request, 1'b0);
      check(src_sw_pending[i], !(i == 0 || i == 2 || i == 4 || i == 5));
      if (!(i == 0 || i == 2 || i == 4 || i == 5)) begin
        src_pulse('0, LIP_SRCS'(1) << i);
        reg_read(LIP_OFS_REQ_STATUS, 8'h00);
      end
    end
    $display("test mapping done");
    // arbitration over the priority codes, fast level 2
    reg_write(LIP_OFS_LEVEL_MASK, 8'h00);
    src_enable <= '1;
    src_pulse('1, '0);
    reg_write(LIP_OFS_SYS_MODE, 8'h0B);
    for (int r = 0; r < 13; r++) begin
      reg_write(LIP_OFS_LEVEL_PRIO, prio_t[r]);
      reg_write(LIP_OFS_LEVEL_MASK, mask_t[r]);
      settle();
      check(int_request, 1'b1);
      check(int_level, lvl_t[r]);
      check(int_source, first_src[lvl_t[r]]);
      check(int_fast, lvl_t[r] == 3'h2);
    end
    reg_read(LIP_OFS_LEVEL_PRIO, 8'h92);
    reg_write(LIP_OFS_LEVEL_MASK, 8'h00);
    settle();
    check(int_request, 1'b0);
    src_pulse('0, ~LIP_HW_CLEARED);
    reg_read(LIP_OFS_REQ_STATUS, 8'h0F);
    $display("test priority done");
    // service of the hardware-cleared sources
    reg_write(LIP_OFS_LEVEL_PRIO, 8'h00);
    reg_write(LIP_OFS_SYS_MODE, 8'h01);
    reg_write(LIP_OFS_LEVEL_MASK, 8'hFF);
    cpu_auto <= 1'b1;
    for (int k = 0; k < 4; k++) begin
      if (k == 0) begin
        for (n = 0; n < 50 && cpu_ack !== 1'b1; n++) @(posedge clk_sys);
        settle();
        check(int_in_service, 1'b1);
        check(int_request, 1'b0);
        check(int_fast, 1'b0);
        reg_read(LIP_OFS_SYS_MODE, 8'h00);
        ack_wait <= 4'h7;
      end
      for (n = 0; n < 200 && done_cnt !== 8'(k + 1); n++) @(posedge clk_sys);
      check(last_src, svc_t[k]);
    end
    settle();
    reg_read(LIP_OFS_SYS_MODE, 8'h01);
    reg_read(LIP_OFS_REQ_STATUS, 8'h00);
    check(int_request, 1'b0);
    $display("test service done");
    complete_run();
  end
endmodule : lip_ctrl_tb_top
